// File: design/fsic_consts.svh
// constants of the flow sensor command decoder: command codes, limits, defaults
// assumes a 20 MHz system clock and a bus host that frames every transfer
`ifndef FSIC_CONSTS_SVH
`define FSIC_CONSTS_SVH
`define FSIC_CMD_WR_DEPTH    8'h05
`define FSIC_CMD_WR_ADDR     8'h08
`define FSIC_CMD_RD_FLOW     8'h81
`define FSIC_CMD_RD_FWD      8'h82
`define FSIC_CMD_RD_REV      8'h83
`define FSIC_CMD_RD_DEPTH    8'h85
`define FSIC_CMD_RD_SERIAL   8'h86
`define FSIC_CMD_RD_ADDR     8'h88
`define FSIC_DEPTH_MAX       16'h000a
`define FSIC_DEPTH_RESET     16'h000a
`define FSIC_ADDR_RESET      7'h04
`define FSIC_BIT_LAST        4'h8
`define FSIC_TX_BIT_LAST     4'h7
`define FSIC_BYTE_CMD        4'h1
`define FSIC_BYTE_DATA_LO    4'h3
`define FSIC_BYTE_MAX        4'hf
`endif

// File: design/fsic_pkg.sv
// types of the flow sensor command decoder
// assumes the constants header is included by the design files
package fsic_pkg;
    // byte engine states, gray along idle-rx-ack-tx-mack
    typedef enum logic [2:0] {
        FSIC_IDLE = 3'h0,
        FSIC_RX   = 3'h1,
        FSIC_ACK  = 3'h3,
        FSIC_TX   = 3'h2,
        FSIC_MACK = 3'h6
    } fsic_state_type;

    // measured flow words, one count per thousandth of ml/min
    typedef struct packed {
        logic signed [31:0] net;
        logic signed [31:0] fwd;
        logic signed [31:0] rev;
    } fsic_flow_type;
endpackage

// File: design/fsic_target.sv
// command decoder behind the sensor's two-wire target port
// assumes scl and sda arrive asynchronously; flow and serial come from this clock domain
`timescale 1ns/1ps
`include "fsic_consts.svh"

module fsic_target (
    input  wire logic            i_clock,          // 20 MHz system clock
    input  wire logic            i_arst_n,         // async reset, active low
    input  wire logic            i_scl,            // serial clock pin from host
    input  wire logic            i_sda_in,         // serial data pin level
    output logic                 o_sda_out,        // data driven when enabled, always low
    output logic                 o_sda_oe,         // high while pulling data low
    input  fsic_pkg::fsic_flow_type i_flow,        // flow words from measurement
    input  wire logic [95:0]     i_serial_number,  // unit_serial_number, first char high
    output logic [15:0]          o_filter_depth,   // current filter depth
    output logic [6:0]           o_target_addr     // current bus address
);
    logic                    rst_s1_q, rst_n;
    logic                    scl_s1_q, scl_s2_q, scl_s3_q;
    logic                    sda_s1_q, sda_s2_q, sda_s3_q;
    logic                    scl_rise, scl_fall, bus_start, bus_stop;
    fsic_pkg::fsic_state_type state_q;
    logic [3:0]              bit_q, byte_q;
    logic [7:0]              sh_q, cmd_q, wdata_q;
    logic                    rw_q;
    logic [95:0]             buf_q;
    logic [15:0]             depth_q;
    logic [6:0]              addr_q;
    logic                    rx_done, wr_apply;
    logic [15:0]             wr_value;

    // reset release through two flops, assert stays asynchronous
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_s1_q <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n    <= rst_s1_q;
        end
    end

    // pin synchronisers; third stage is history for edge finding only
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            scl_s1_q <= 1'b1;
            scl_s2_q <= 1'b1;
            scl_s3_q <= 1'b1;
            sda_s1_q <= 1'b1;
            sda_s2_q <= 1'b1;
            sda_s3_q <= 1'b1;
        end else begin
            scl_s1_q <= i_scl;
            scl_s2_q <= scl_s1_q;
            scl_s3_q <= scl_s2_q;
            sda_s1_q <= i_sda_in;
            sda_s2_q <= sda_s1_q;
            sda_s3_q <= sda_s2_q;
        end
    end

    // bus events; start and stop are data edges while the clock is high
    assign scl_rise  = scl_s2_q & ~scl_s3_q;
    assign scl_fall  = ~scl_s2_q & scl_s3_q;
    assign bus_start = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
    assign bus_stop  = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;
    assign rx_done   = (state_q == fsic_pkg::FSIC_RX) && scl_fall && (bit_q == `FSIC_BIT_LAST);
    assign wr_value  = {wdata_q, sh_q};
    assign wr_apply  = rx_done && !rw_q && (byte_q == `FSIC_BYTE_DATA_LO);

    // answer buffer for a read command, most significant byte at the top
    function automatic logic [95:0] fsic_answer(input logic [7:0] cmd);
        logic [95:0] r;
        r = '0;
        if (cmd == `FSIC_CMD_RD_FLOW) begin
            r[95:64] = i_flow.net;
        end else if (cmd == `FSIC_CMD_RD_FWD) begin
            r[95:64] = i_flow.fwd;
        end else if (cmd == `FSIC_CMD_RD_REV) begin
            r[95:64] = i_flow.rev;
        end else if (cmd == `FSIC_CMD_RD_DEPTH) begin
            r[95:80] = depth_q;
        end else if (cmd == `FSIC_CMD_RD_SERIAL) begin
            r = i_serial_number;
        end else if (cmd == `FSIC_CMD_RD_ADDR) begin
            r[87:80] = {addr_q, 1'b0};
        end
        return r;
    endfunction

    // byte engine; a start from any state restarts the address phase
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= fsic_pkg::FSIC_IDLE;
            bit_q   <= 4'h0;
            byte_q  <= 4'h0;
            sh_q    <= 8'h00;
            rw_q    <= 1'b0;
        end else if (bus_start) begin
            state_q <= fsic_pkg::FSIC_RX;
            bit_q   <= 4'h0;
            byte_q  <= 4'h0;
        end else if (bus_stop) begin
            state_q <= fsic_pkg::FSIC_IDLE;
        end else begin
            case (state_q)
                fsic_pkg::FSIC_RX: begin
                    if (scl_rise) begin
                        sh_q  <= {sh_q[6:0], sda_s2_q};
                        bit_q <= bit_q + 4'h1;
                    end
                    if (rx_done) begin
                        bit_q <= 4'h0;
                        if (byte_q == 4'h0) begin
                            rw_q <= sh_q[0];
                        end
                        // other targets' traffic is ignored until the next start
                        if (byte_q == 4'h0 && sh_q[7:1] != addr_q) begin
                            state_q <= fsic_pkg::FSIC_IDLE;
                        end else begin
                            state_q <= fsic_pkg::FSIC_ACK;
                        end
                    end
                end
                fsic_pkg::FSIC_ACK: begin
                    if (scl_fall) begin
                        state_q <= rw_q ? fsic_pkg::FSIC_TX : fsic_pkg::FSIC_RX;
                        if (byte_q != `FSIC_BYTE_MAX) begin
                            byte_q <= byte_q + 4'h1;
                        end
                    end
                end
                fsic_pkg::FSIC_TX: begin
                    if (scl_fall) begin
                        bit_q <= bit_q + 4'h1;
                        if (bit_q == `FSIC_TX_BIT_LAST) begin
                            bit_q   <= 4'h0;
                            state_q <= fsic_pkg::FSIC_MACK;
                        end
                    end
                end
                fsic_pkg::FSIC_MACK: begin
                    // a host nack ends the read; the pin stays released
                    if (scl_rise && sda_s2_q) begin
                        state_q <= fsic_pkg::FSIC_IDLE;
                    end else if (scl_fall) begin
                        state_q <= fsic_pkg::FSIC_TX;
                    end
                end
                default: begin
                    state_q <= fsic_pkg::FSIC_IDLE;
                end
            endcase
        end
    end

    // command capture and write data gathering
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            cmd_q   <= 8'h00;
            wdata_q <= 8'h00;
        end else if (rx_done && !rw_q && byte_q == `FSIC_BYTE_CMD) begin
            cmd_q <= sh_q;
        end else if (rx_done && !rw_q) begin
            wdata_q <= sh_q;
        end
    end

    // answer shifter: loaded at the command byte, shifted on each sent bit
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            buf_q <= '0;
        end else if (rx_done && !rw_q && byte_q == `FSIC_BYTE_CMD) begin
            buf_q <= fsic_answer(sh_q);
        end else if (state_q == fsic_pkg::FSIC_TX && scl_fall) begin
            buf_q <= {buf_q[94:0], 1'b0};
        end
    end

    // filter depth; out-of-range writes are dropped so the old depth stays
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            depth_q <= `FSIC_DEPTH_RESET;
        end else if (wr_apply && cmd_q == `FSIC_CMD_WR_DEPTH && wr_value <= `FSIC_DEPTH_MAX) begin
            depth_q <= wr_value;
        end
    end

    // bus address; takes effect from the next start, current transfer unaffected
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            addr_q <= `FSIC_ADDR_RESET;
        end else if (wr_apply && cmd_q == `FSIC_CMD_WR_ADDR) begin
            addr_q <= wr_value[7:1];
        end
    end

    // open-drain data: pull low for acks and for zero answer bits
    assign o_sda_out      = 1'b0;
    assign o_sda_oe       = (state_q == fsic_pkg::FSIC_ACK) ||
                            (state_q == fsic_pkg::FSIC_TX && !buf_q[95]);
    assign o_filter_depth = depth_q;
    assign o_target_addr  = addr_q;

    property p_depth_range;
        @(posedge i_clock) disable iff (!rst_n) depth_q <= `FSIC_DEPTH_MAX;
    endproperty
    a_depth_range: assert property (p_depth_range) else $error("depth above limit");

    property p_depth_write;
        @(posedge i_clock) disable iff (!rst_n)
            (wr_apply && cmd_q == `FSIC_CMD_WR_DEPTH && wr_value <= `FSIC_DEPTH_MAX)
            |=> depth_q == $past(wr_value);
    endproperty
    a_depth_write: assert property (p_depth_write) else $error("depth write lost");

    property p_addr_write;
        @(posedge i_clock) disable iff (!rst_n)
            (wr_apply && cmd_q == `FSIC_CMD_WR_ADDR) |=> addr_q == $past(wr_value[7:1]);
    endproperty
    a_addr_write: assert property (p_addr_write) else $error("address write lost");

    property p_addr_read;
        @(posedge i_clock) disable iff (!rst_n)
            (rx_done && !rw_q && byte_q == `FSIC_BYTE_CMD && sh_q == `FSIC_CMD_RD_ADDR)
            |=> buf_q[95:80] == {8'h00, $past(addr_q), 1'b0};
    endproperty
    a_addr_read: assert property (p_addr_read) else $error("address answer wrong");

    property p_addr_match;
        @(posedge i_clock) disable iff (!rst_n)
            (rx_done && byte_q == 4'h0 && !bus_start && !bus_stop)
            |=> (state_q == fsic_pkg::FSIC_ACK) == ($past(sh_q[7:1]) == addr_q);
    endproperty
    a_addr_match: assert property (p_addr_match) else $error("address match wrong");

    property p_flow_load;
        @(posedge i_clock) disable iff (!rst_n)
            (rx_done && !rw_q && byte_q == `FSIC_BYTE_CMD && sh_q == `FSIC_CMD_RD_FLOW)
            |=> buf_q[95:64] == $past(i_flow.net);
    endproperty
    a_flow_load: assert property (p_flow_load) else $error("flow answer wrong");

    property p_serial_load;
        @(posedge i_clock) disable iff (!rst_n)
            (rx_done && !rw_q && byte_q == `FSIC_BYTE_CMD && sh_q == `FSIC_CMD_RD_SERIAL)
            |=> buf_q == $past(i_serial_number);
    endproperty
    a_serial_load: assert property (p_serial_load) else $error("serial answer wrong");

    // each sent bit after the first of a byte is the next one of the snapshot, msb first
    property p_tx_bit;
        @(posedge i_clock) disable iff (!rst_n)
            (state_q == fsic_pkg::FSIC_TX && scl_fall && bit_q != `FSIC_TX_BIT_LAST)
            |=> o_sda_oe == !$past(buf_q[94]);
    endproperty
    a_tx_bit: assert property (p_tx_bit) else $error("sent bit wrong");

    // data may only move while the clock is low, else the host sees a start or stop
    property p_sda_hold;
        @(posedge i_clock) disable iff (!rst_n)
            (scl_s2_q && scl_s3_q && !bus_start && !bus_stop) |=> $stable(o_sda_oe);
    endproperty
    a_sda_hold: assert property (p_sda_hold) else $error("data moved with clock high");
endmodule

// File: testbench/fsic_host_model.sv
// two-wire bus host model: start, stop, byte write and byte read for the bench
// assumes a pull-up on sda that the bench resolves, and a device clocked by i_clock
`timescale 1ns/1ps

module fsic_host_model (
    input  wire logic i_clock, // bench clock that paces the bus
    input  wire logic i_sda,   // resolved data line level
    output logic      o_scl,   // serial clock, idles high
    output logic      o_sda    // host data drive, 1 releases the line
);
    // idle bus: both lines released
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end

    // a bus clock is 8 system clocks; moves land 1 ns after the edge
    task automatic tick(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask

    // data moves mid-low so the device never sees it change with scl
    task automatic bit_io(input logic b, output logic r);
        o_scl = 1'b0;
        tick(2);
        o_sda = b;
        tick(2);
        o_scl = 1'b1;
        tick(2);
        r = i_sda;
        tick(2);
    endtask

    // start, also used as repeated start before the read direction
    task automatic start();
        o_scl = 1'b0;
        tick(2);
        o_sda = 1'b1;
        tick(2);
        o_scl = 1'b1;
        tick(2);
        o_sda = 1'b0;
        tick(2);
    endtask

    task automatic stop();
        o_scl = 1'b0;
        tick(2);
        o_sda = 1'b0;
        tick(2);
        o_scl = 1'b1;
        tick(2);
        o_sda = 1'b1;
        tick(4);
    endtask

    // byte out msb first, then the device's acknowledge bit
    task automatic wr_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], r);
        end
        bit_io(1'b1, r);
        ack = (r === 1'b0);
    endtask

    // byte in msb first; the host nacks the last byte to end the read
    task automatic rd_byte(input logic nack, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, b[i]);
        end
        bit_io(nack, r);
    endtask
endmodule

// File: testbench/tb.sv
// self-checking bench of the flow sensor command decoder
// assumes the host model drives the bus and sda has a pull-up
`timescale 1ns/1ps

module tb;
    logic                    i_clock = 1'b0;
    logic                    i_arst_n = 1'b0;
    logic                    scl;
    logic                    host_sda;
    logic                    sda_oe;
    logic                    sda_out;
    logic [15:0]             depth;
    logic [6:0]              addr;
    logic [6:0]              cur = 7'h04;
    logic [31:0]             fw [3] = '{32'hfffffffb, 32'h0001e240, 32'h00000007};
    logic [95:0]             serial = "SN0123456789";
    fsic_pkg::fsic_flow_type flow;
    int                      fails = 0;
    int                      comparisons = 0;
    wire logic               sda_line = host_sda & ~(sda_oe & ~sda_out);

    assign flow = {fw[0], fw[1], fw[2]};
    always #25 i_clock = ~i_clock;

    fsic_target u_fsic_target (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_scl(scl),
        .i_sda_in(sda_line), .o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_flow(flow),
        .i_serial_number(serial), .o_filter_depth(depth), .o_target_addr(addr));
    fsic_host_model u_fsic_host_model (.i_clock(i_clock), .i_sda(sda_line), .o_scl(scl),
        .o_sda(host_sda));

    task automatic check(input logic [95:0] seen, input logic [95:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // write command with two data bytes, every byte must be acked
    task automatic wr_cmd(input logic [7:0] c, input logic [15:0] d);
        logic [3:0] k;
        u_fsic_host_model.start();
        u_fsic_host_model.wr_byte({cur, 1'b0}, k[3]);
        u_fsic_host_model.wr_byte(c, k[2]);
        u_fsic_host_model.wr_byte(d[15:8], k[1]);
        u_fsic_host_model.wr_byte(d[7:0], k[0]);
        u_fsic_host_model.stop();
        check(k, 4'hf);
    endtask

    // read command: code, repeated start, n bytes gathered msb first
    task automatic rd_cmd(input logic [7:0] c, input int n, output logic [95:0] v);
        logic [2:0] k;
        logic [7:0] b;
        v = '0;
        u_fsic_host_model.start();
        u_fsic_host_model.wr_byte({cur, 1'b0}, k[2]);
        u_fsic_host_model.wr_byte(c, k[1]);
        u_fsic_host_model.start();
        u_fsic_host_model.wr_byte({cur, 1'b1}, k[0]);
        for (int i = 0; i < n; i++) begin
            u_fsic_host_model.rd_byte(i == n - 1, b);
            v = {v[87:0], b};
        end
        u_fsic_host_model.stop();
        check(k, 3'h7);
    endtask

    // depth write at the edges of its range, out of range dropped, read back
    task automatic t_depth();
        logic [95:0] v;
        check(depth, 16'h000a);
        wr_cmd(8'h05, 16'h0005);
        check(depth, 16'h0005);
        wr_cmd(8'h05, 16'h000b);
        check(depth, 16'h0005);
        rd_cmd(8'h85, 2, v);
        check(v, 16'h0005);
        wr_cmd(8'h05, 16'h000a);
        check(depth, 16'h000a);
        wr_cmd(8'h05, 16'h0000);
        check(depth, 16'h0000);
    endtask

    task automatic t_flow();
        logic [95:0] v;
        for (int i = 0; i < 3; i++) begin
            rd_cmd(8'h81 + 8'(i), 4, v);
            check(v, fw[i]);
        end
        rd_cmd(8'h86, 12, v);
        check(v, serial);
        rd_cmd(8'h80, 2, v);
        check(v, 96'h0);
    endtask

    // mid-run reset brings depth and address back to their defaults
    task automatic t_reset();
        logic [95:0] v;
        i_arst_n = 1'b0;
        u_fsic_host_model.tick(2);
        check(depth, 16'h000a);
        check(addr, 7'h04);
        i_arst_n = 1'b1;
        u_fsic_host_model.tick(6);
        cur = 7'h04;
        rd_cmd(8'h85, 2, v);
        check(v, 16'h000a);
    endtask

    // new address takes over; the old one is no longer answered
    task automatic t_addr();
        logic [95:0] v;
        logic        k;
        check(addr, 7'h04);
        wr_cmd(8'h08, 16'h000c);
        cur = 7'h06;
        check(addr, 7'h06);
        u_fsic_host_model.start();
        u_fsic_host_model.wr_byte(8'h08, k);
        u_fsic_host_model.stop();
        check(k, 1'b0);
        rd_cmd(8'h88, 2, v);
        check(v, 16'h000c);
    endtask

    task automatic end_sim();
        $display("fails=%0d comparisons=%0d", fails, comparisons);
        if (fails == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // about 77 bus bytes of 3.6 us each; the limit leaves ample margin
    initial begin
        #2000000;
        fails++;
        end_sim();
    end

    initial begin
        repeat (4) @(posedge i_clock);
        #1;
        i_arst_n = 1'b1;
        u_fsic_host_model.tick(6);
        t_depth();
        t_flow();
        t_addr();
        t_reset();
        end_sim();
    end
endmodule
